//--- hw/ext_edge_irq_acknowledge.v
// Edge detectors, request flags, status word and acknowledgment sequencer
`timescale 1ns/1ps
`include "irq_ack_consts.vh"
// Function
// - Enable pair per input: 00 off, 01 falling, 10 rising, 11 both edges.
// - Bit n of both select registers controls external input n, n 0..7.
// - Reset clears both edge select registers, disabling detection.
// - Edge select registers take byte writes and single-bit writes.
// - Reset sets the status word to 06H.
// - Status word has byte access, bit access, enable and disable commands.
// - On acceptance with level not 00, service level gets level minus one.
// - Eligible when flagged and unmasked; accepted only with global enable set.
// - Never accept a request below the level in service.
// - Request to vector load takes 9 to 16 clocks.
// - Simultaneous requests: best level first, default order breaks ties.
// - Unaccepted requests stay pending and go once acceptable.
// - Acceptance pushes status then PC, clears enable, sets level, loads vector.
// - Push-status saves the status word; returns and pop restore it.
// - Software trap is always accepted.
// - Trap pushes status then PC, clears enable, vectors to 0007EH/0007FH.
// - Level code 00 level 0/1, 01 level 2, 10 level 3, 11 idle.
// - With enable set, higher level requests nest, and level 0 nests on level 0; other equal and lower ones wait.
module ext_edge_irq_acknowledge (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [21:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [7:0] ext_irq_input,
  input wire [7:0] periph_req,
  input wire core_boundary,
  input wire [19:0] core_pc,
  input wire unmask_all_instruction,
  input wire mask_all_instruction,
  input wire software_trap,
  input wire push_status,
  input wire restore_status,
  input wire [7:0] restore_data,
  output reg stack_push_reg,
  output reg [19:0] stack_data_reg,
  output reg vector_load_reg,
  output reg [19:0] vector_addr_reg,
  output wire [7:0] program_status_word,
  output wire busy
);
  localparam S_IDLE = 1'b0;
  localparam S_SEQ = 1'b1;

  reg [7:0] rise_sel_reg;
  reg [7:0] fall_sel_reg;
  reg [7:0] psw_reg;
  reg [15:0] mask_reg;
  reg [15:0] prio_low_reg;
  reg [15:0] prio_high_reg;
  reg [15:0] req_reg;
  reg state_reg;
  reg [3:0] cnt_reg;
  reg trap_pend_reg;
  reg seq_trap_reg;
  reg [19:0] seq_vec_reg;
  reg [19:0] pc_hold_reg;

  reg [7:0] rise_sel_next;
  reg [7:0] fall_sel_next;
  reg [7:0] psw_next;
  reg [15:0] req_clr;

  wire [7:0] edge_pulse;
  wire [15:0] req_set;
  wire [15:0] eligible;
  wire any_req;
  wire [3:0] win_idx;
  wire [1:0] win_level;
  wire [1:0] isp;
  wire ie;
  wire wr_en;
  wire rd_setup;
  wire [19:0] idx;
  wire hit;
  wire start_trap;
  wire accept;
  wire [2:0] bop_bit;
  wire bop_val;
  wire [1:0] bop_tgt;

  // ------------------------------------------------------------
  // Edge detectors
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_edge
      edge_detect u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ext_irq_input[g]),
        .rise_enable_bit(rise_sel_reg[g]),
        .fall_enable_bit(fall_sel_reg[g]),
        .edge_pulse(edge_pulse[g])
      );
    end
  endgenerate

  assign req_set = {periph_req, edge_pulse};

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign pready = 1'b1;
  assign idx = paddr[21:2];
  assign hit = (idx >= `IDX_RISE_SEL) && (idx <= `IDX_BIT_OP);
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign bop_bit = pwdata[`BOP_BIT_LSB +: 3];
  assign bop_val = pwdata[`BOP_VAL_BIT];
  assign bop_tgt = pwdata[`BOP_TGT_LSB +: 2];

  assign ie = psw_reg[`PSW_IE_BIT];
  assign isp = {psw_reg[`PSW_SERVICE_LEVEL_BIT1_BIT], psw_reg[`PSW_SERVICE_LEVEL_BIT0_BIT]};
  assign program_status_word = psw_reg;
  assign busy = (state_reg == S_SEQ);

  // Read data registered in setup so it is stable for the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (idx)
        `IDX_RISE_SEL: prdata <= {24'h000000, rise_sel_reg};
        `IDX_FALL_SEL: prdata <= {24'h000000, fall_sel_reg};
        `IDX_PSW: prdata <= {24'h000000, psw_reg};
        `IDX_MASK: prdata <= {16'h0000, mask_reg};
        `IDX_PRIO_LOW: prdata <= {16'h0000, prio_low_reg};
        `IDX_PRIO_HIGH: prdata <= {16'h0000, prio_high_reg};
        `IDX_REQ_FLAGS: prdata <= {16'h0000, req_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Arbitration and acceptance
  // ------------------------------------------------------------
  // flagged and unmasked
  assign eligible = req_reg & ~mask_reg;

  priority_arbiter u_arb (
    .eligible(eligible),
    .priority_bit_low(prio_low_reg),
    .priority_bit_high(prio_high_reg),
    .any_req(any_req),
    .win_idx(win_idx),
    .win_level(win_level)
  );

  assign start_trap = (state_reg == S_IDLE) & (software_trap | trap_pend_reg);
  // level must not be below service level
  assign accept = (state_reg == S_IDLE) & ~start_trap & any_req & ie &
                  core_boundary & (win_level <= isp);

  // ------------------------------------------------------------
  // Edge select, mask and priority registers
  // ------------------------------------------------------------
  // byte write or single bit write
  always @* begin
    rise_sel_next = rise_sel_reg;
    fall_sel_next = fall_sel_reg;
    if (wr_en && idx == `IDX_RISE_SEL) begin
      rise_sel_next = pwdata[7:0];
    end
    if (wr_en && idx == `IDX_FALL_SEL) begin
      fall_sel_next = pwdata[7:0];
    end
    if (wr_en && idx == `IDX_BIT_OP && bop_tgt == `BOP_TGT_RISE) begin
      rise_sel_next[bop_bit] = bop_val;
    end
    if (wr_en && idx == `IDX_BIT_OP && bop_tgt == `BOP_TGT_FALL) begin
      fall_sel_next[bop_bit] = bop_val;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_sel_reg <= `RST_EDGE_SEL;
      fall_sel_reg <= `RST_EDGE_SEL;
      mask_reg <= `RST_MASK;
      prio_low_reg <= `RST_PRIO;
      prio_high_reg <= `RST_PRIO;
    end else begin
      rise_sel_reg <= rise_sel_next;
      fall_sel_reg <= fall_sel_next;
      if (wr_en && idx == `IDX_MASK) begin
        mask_reg <= pwdata[15:0];
      end
      if (wr_en && idx == `IDX_PRIO_LOW) begin
        prio_low_reg <= pwdata[15:0];
      end
      if (wr_en && idx == `IDX_PRIO_HIGH) begin
        prio_high_reg <= pwdata[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Request flags
  // ------------------------------------------------------------
  always @* begin
    req_clr = 16'h0000;
    if (wr_en && idx == `IDX_REQ_FLAGS) begin
      req_clr = pwdata[15:0];
    end
    if (accept) begin
      req_clr[win_idx] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg <= 16'h0000;
    end else begin
      req_reg <= (req_reg & ~req_clr) | req_set;
    end
  end

  // ------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------
  // Acceptance outranks instructions and bus writes in the same cycle
  always @* begin
    psw_next = psw_reg;
    if (unmask_all_instruction) begin
      psw_next[`PSW_IE_BIT] = 1'b1;
    end
    if (mask_all_instruction) begin
      psw_next[`PSW_IE_BIT] = 1'b0;
    end
    if (wr_en && idx == `IDX_PSW) begin
      psw_next = pwdata[7:0];
    end
    if (wr_en && idx == `IDX_BIT_OP && bop_tgt == `BOP_TGT_PSW) begin
      psw_next[bop_bit] = bop_val;
    end
    if (restore_status) begin
      psw_next = restore_data;
    end
    if (start_trap) begin
      psw_next[`PSW_IE_BIT] = 1'b0;
    end
    if (accept) begin
      psw_next[`PSW_IE_BIT] = 1'b0;
      // level 0 and 1 share code 00
      if (win_level != 2'h0) begin
        {psw_next[`PSW_SERVICE_LEVEL_BIT1_BIT], psw_next[`PSW_SERVICE_LEVEL_BIT0_BIT]} = win_level - 2'h1;
      end else begin
        {psw_next[`PSW_SERVICE_LEVEL_BIT1_BIT], psw_next[`PSW_SERVICE_LEVEL_BIT0_BIT]} = 2'h0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psw_reg <= `RST_PSW;
    end else begin
      psw_reg <= psw_next;
    end
  end

  // ------------------------------------------------------------
  // Acknowledgment sequencer
  // ------------------------------------------------------------
  // Trap during a running sequence waits here rather than being lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_pend_reg <= 1'b0;
    end else if (start_trap) begin
      trap_pend_reg <= 1'b0;
    end else if (software_trap) begin
      trap_pend_reg <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      seq_trap_reg <= 1'b0;
      seq_vec_reg <= 20'h00000;
      pc_hold_reg <= 20'h00000;
      stack_push_reg <= 1'b0;
      stack_data_reg <= 20'h00000;
      vector_load_reg <= 1'b0;
      vector_addr_reg <= 20'h00000;
    end else begin
      stack_push_reg <= 1'b0;
      vector_load_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_trap || accept) begin
            state_reg <= S_SEQ;
            cnt_reg <= 4'h1;
            seq_trap_reg <= start_trap;
            seq_vec_reg <= start_trap ? `TRAP_VECTOR :
                           (`VEC_BASE + {15'h0000, win_idx, 1'b0});
            pc_hold_reg <= core_pc;
            stack_push_reg <= 1'b1;
            stack_data_reg <= {12'h000, psw_reg};
          end else if (push_status) begin
            stack_push_reg <= 1'b1;
            stack_data_reg <= {12'h000, psw_reg};
          end
        end
        S_SEQ: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'h1) begin
            stack_push_reg <= 1'b1;
            stack_data_reg <= pc_hold_reg;
          end
          // vector lands nine clocks after the flag
          if (cnt_reg == `SEQ_LAST_CNT) begin
            vector_load_reg <= 1'b1;
            vector_addr_reg <= seq_vec_reg;
            state_reg <= S_IDLE;
            cnt_reg <= 4'h0;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          cnt_reg <= 4'h0;
        end
      endcase
    end
  end
endmodule

//--- inc/irq_ack_consts.vh
// Constants for the external edge interrupt and acknowledgment block
`ifndef IRQ_ACK_CONSTS_VH
`define IRQ_ACK_CONSTS_VH

// ------------------------------------------------------------
// Register indices (byte address = index * 4)
// ------------------------------------------------------------
`define IDX_RISE_SEL 20'hFFF38
`define IDX_FALL_SEL 20'hFFF39
`define IDX_PSW 20'hFFF3A
`define IDX_MASK 20'hFFF3B
`define IDX_PRIO_LOW 20'hFFF3C
`define IDX_PRIO_HIGH 20'hFFF3D
`define IDX_REQ_FLAGS 20'hFFF3E
`define IDX_BIT_OP 20'hFFF3F

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_EDGE_SEL 8'h00
`define RST_PSW 8'h06
`define RST_MASK 16'hFFFF
`define RST_PRIO 16'hFFFF

// ------------------------------------------------------------
// Status word fields
// ------------------------------------------------------------
`define PSW_IE_BIT 7
`define PSW_SERVICE_LEVEL_BIT1_BIT 2
`define PSW_SERVICE_LEVEL_BIT0_BIT 1

// ------------------------------------------------------------
// Bit operation register fields
// ------------------------------------------------------------
`define BOP_BIT_LSB 0
`define BOP_VAL_BIT 3
`define BOP_TGT_LSB 4
`define BOP_TGT_RISE 2'h0
`define BOP_TGT_FALL 2'h1
`define BOP_TGT_PSW 2'h2

// ------------------------------------------------------------
// Vectors and timing
// ------------------------------------------------------------
`define TRAP_VECTOR 20'h0007E
`define VEC_BASE 20'h00004
`define LAT_MIN_CLOCKS 9
`define LAT_MAX_CLOCKS 16
`define SEQ_LAST_CNT (`LAT_MIN_CLOCKS - 1)

`endif

//--- hw/edge_detect.v
// Pin synchroniser and selectable edge detector for one external input
`timescale 1ns/1ps
module edge_detect (
  input wire pclk,
  input wire presetn,
  input wire pin,
  input wire rise_enable_bit,
  input wire fall_enable_bit,
  output wire edge_pulse
);
  reg sync1_reg;
  reg sync2_reg;
  reg prev_reg;

  // ------------------------------------------------------------
  // Synchroniser
  // ------------------------------------------------------------
  // two-stage sync
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign edge_pulse = (rise_enable_bit & sync2_reg & ~prev_reg) |
                      (fall_enable_bit & ~sync2_reg & prev_reg);
endmodule

//--- hw/priority_arbiter.v
// Picks the eligible source with best programmed level, then lowest index
`timescale 1ns/1ps
module priority_arbiter (
  input wire [15:0] eligible,
  input wire [15:0] priority_bit_low,
  input wire [15:0] priority_bit_high,
  output reg any_req,
  output reg [3:0] win_idx,
  output reg [1:0] win_level
);
  integer i;

  always @* begin
    any_req = 1'b0;
    win_idx = 4'h0;
    win_level = 2'h3;
    for (i = 15; i >= 0; i = i - 1) begin
      if (eligible[i] && ({priority_bit_high[i], priority_bit_low[i]} <= win_level)) begin
        any_req = 1'b1;
        win_idx = i[3:0];
        win_level = {priority_bit_high[i], priority_bit_low[i]};
      end
    end
  end
endmodule

//--- sim/irq_ack_sva.sv
// Port-level checks for the acknowledgment block
`timescale 1ns/1ps
module irq_ack_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [21:0] paddr,
  input wire pslverr,
  input wire software_trap,
  input wire push_status,
  input wire stack_push_reg,
  input wire [19:0] stack_data_reg,
  input wire vector_load_reg,
  input wire [19:0] vector_addr_reg,
  input wire [7:0] program_status_word,
  input wire busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_seq_length: assert property ($rose(busy) |-> ##8 vector_load_reg)
    else $error("sequence length wrong");
  a_ie_cleared: assert property ($rose(busy) |-> !program_status_word[7])
    else $error("enable not cleared");
  a_push_order: assert property ($rose(busy) |-> stack_push_reg &&
    stack_data_reg[7:0] == $past(program_status_word) ##1 stack_push_reg ##1 !stack_push_reg)
    else $error("push order wrong");
  a_trap_vector: assert property (software_trap && !busy |->
    ##[8:9] (vector_load_reg && vector_addr_reg == 20'h0007E))
    else $error("trap vector wrong");
  a_trap_taken: assert property (software_trap && !busy |=> ##[0:1] busy)
    else $error("trap not taken");
  a_status_push: assert property (push_status && !busy |=> stack_push_reg &&
    stack_data_reg[7:0] == $past(program_status_word))
    else $error("status not pushed");
  a_vec_hold: assert property (!vector_load_reg |-> $stable(vector_addr_reg))
    else $error("vector moved");
  a_map_err: assert property (psel && penable |->
    pslverr == (paddr[21:5] != 17'h1FFE7))
    else $error("error response wrong");
endmodule
bind ext_edge_irq_acknowledge irq_ack_sva chk_u (.pclk, .presetn, .psel, .penable, .paddr,
  .pslverr, .software_trap, .push_status, .stack_push_reg, .stack_data_reg, .vector_load_reg,
  .vector_addr_reg, .program_status_word, .busy);

//--- sim/core_model.sv
// Core model: boundary, program counter, stack capture
`timescale 1ns/1ps
module core_model (
  input wire pclk,
  input wire presetn,
  input wire stall,
  input wire stack_push_reg,
  input wire [19:0] stack_data_reg,
  input wire vector_load_reg,
  input wire [19:0] vector_addr_reg,
  output wire core_boundary,
  output reg [19:0] core_pc,
  output reg [19:0] push_first,
  output reg [19:0] push_last
);
  // Slow core: no boundary while stalled
  assign core_boundary = !stall;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_pc <= 20'h00100;
      push_first <= 20'h00000;
      push_last <= 20'h00000;
    end else begin
      if (vector_load_reg)
        core_pc <= vector_addr_reg;
      if (stack_push_reg) begin
        push_first <= push_last;
        push_last <= stack_data_reg;
      end
    end
  end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the edge interrupt acknowledgment block
`timescale 1ns/1ps
`include "irq_ack_consts.vh"
module tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [21:0] paddr = 22'h0;
  reg [31:0] pwdata = 32'h0;
  reg [7:0] ext_irq_input = 8'h00, periph_req = 8'h00, restore_data = 8'h00;
  reg unmask = 1'b0, mask = 1'b0, trap = 1'b0, push = 1'b0, restore = 1'b0, stall = 1'b0;
  wire pready, pslverr, stack_push_reg, vector_load_reg, busy, core_boundary;
  wire [31:0] prdata;
  wire [19:0] stack_data_reg, vector_addr_reg, core_pc, push_first, push_last;
  wire [7:0] program_status_word;
  reg [31:0] rd;
  reg err;
  integer num_errors, total_checks, n;
  ext_edge_irq_acknowledge dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_irq_input(ext_irq_input),
    .periph_req(periph_req), .core_boundary(core_boundary), .core_pc(core_pc),
    .unmask_all_instruction(unmask), .mask_all_instruction(mask), .software_trap(trap),
    .push_status(push), .restore_status(restore), .restore_data(restore_data),
    .stack_push_reg(stack_push_reg), .stack_data_reg(stack_data_reg),
    .vector_load_reg(vector_load_reg), .vector_addr_reg(vector_addr_reg),
    .program_status_word(program_status_word), .busy(busy));
  core_model core_u (.pclk(pclk), .presetn(presetn), .stall(stall),
    .stack_push_reg(stack_push_reg), .stack_data_reg(stack_data_reg),
    .vector_load_reg(vector_load_reg), .vector_addr_reg(vector_addr_reg),
    .core_boundary(core_boundary), .core_pc(core_pc), .push_first(push_first),
    .push_last(push_last));
  initial begin
    forever #4 pclk = ~pclk;
  end
  task tally_and_finish;
    begin
      if (num_errors == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [19:0] idx, input [31:0] d);
    integer i;
    begin
      i = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 20) begin
        @(posedge pclk);
        i = i + 1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t bus answer missing", $time);
        tally_and_finish;
      end
    end
  endtask
  task wait_vec;
    begin
      n = 0;
      while (vector_load_reg !== 1'b1 && n < 40) begin
        @(negedge pclk);
        n = n + 1;
      end
      if (n == 40) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t no vector load", $time);
        tally_and_finish;
      end
    end
  endtask
  task go_restore(input [7:0] v);
    begin
      @(posedge pclk);
      restore <= 1'b1;
      restore_data <= v;
      @(posedge pclk);
      restore <= 1'b0;
    end
  endtask
  task go_unmask;
    begin
      @(posedge pclk);
      unmask <= 1'b1;
      @(posedge pclk);
      unmask <= 1'b0;
    end
  endtask
  task t_regs;
    begin
      apb(0, `IDX_RISE_SEL, 0); chk(rd, 0);
      apb(0, `IDX_FALL_SEL, 0); chk(rd, 0);
      chk(program_status_word, 8'h06);
      apb(1, `IDX_RISE_SEL, 32'hA5);
      apb(1, `IDX_BIT_OP, 32'h05);
      apb(0, `IDX_RISE_SEL, 0); chk(rd, 32'h85);
      apb(1, `IDX_BIT_OP, 32'h1B);
      apb(0, `IDX_FALL_SEL, 0); chk(rd, 32'h08);
      apb(0, 20'hFFF40, 0); chk(err, 1);
      apb(1, `IDX_RISE_SEL, 0);
      apb(1, `IDX_FALL_SEL, 0);
    end
  endtask
  task t_edges;
    integer m;
    begin
      for (m = 0; m < 4; m = m + 1) begin
        apb(1, `IDX_RISE_SEL, m[1] ? 32'h4 : 32'h0);
        apb(1, `IDX_FALL_SEL, m[0] ? 32'h4 : 32'h0);
        @(posedge pclk) ext_irq_input[2] <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(0, `IDX_REQ_FLAGS, 0); chk(rd[2], m[1]);
        apb(1, `IDX_REQ_FLAGS, 32'h4);
        @(posedge pclk) ext_irq_input[2] <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(0, `IDX_REQ_FLAGS, 0); chk(rd[2], m[0]);
        apb(1, `IDX_REQ_FLAGS, 32'h4);
      end
    end
  endtask
  task t_accept;
    begin
      apb(1, `IDX_PRIO_LOW, 32'hFFDF);
      apb(1, `IDX_PRIO_HIGH, 32'hFDFF);
      apb(1, `IDX_MASK, 32'hFDDF);
      apb(1, `IDX_RISE_SEL, 32'h20);
      @(posedge pclk) ext_irq_input[5] <= 1'b1;
      periph_req[1] <= 1'b1;
      @(posedge pclk) periph_req[1] <= 1'b0;
      repeat (20) @(posedge pclk);
      chk(busy, 0);
      chk(program_status_word, 8'h06);
      go_unmask;
      wait_vec;
      chk(vector_addr_reg, 20'h00016);
      chk(program_status_word, 8'h00);
      chk(push_first[7:0], 8'h86);
      chk(push_last, 20'h00100);
      go_unmask;
      repeat (20) @(posedge pclk);
      chk(busy, 0);
      chk(program_status_word, 8'h80);
      stall <= 1'b1;
      go_restore(8'h86);
      repeat (10) @(posedge pclk);
      chk(busy, 0);
      chk(program_status_word, 8'h86);
      stall <= 1'b0;
      wait_vec;
      chk(vector_addr_reg, 20'h0000E);
      chk(program_status_word, 8'h02);
      // Level 2 in service: a level 1 request nests
      go_unmask;
      @(posedge pclk) periph_req[1] <= 1'b1;
      @(posedge pclk) periph_req[1] <= 1'b0;
      wait_vec;
      chk(n >= 9 && n <= 16, 1);
      chk(vector_addr_reg, 20'h00016);
      // Level 1 in service: another level 1 request must wait
      go_unmask;
      @(posedge pclk) periph_req[1] <= 1'b1;
      @(posedge pclk) periph_req[1] <= 1'b0;
      repeat (20) @(posedge pclk);
      chk(program_status_word, 8'h80);
      apb(0, `IDX_REQ_FLAGS, 0); chk(rd, 32'h200);
      apb(1, `IDX_REQ_FLAGS, 32'h200);
    end
  endtask
  task t_trap;
    begin
      go_unmask;
      @(posedge pclk) mask <= 1'b1;
      @(posedge pclk) mask <= 1'b0;
      @(negedge pclk) chk(program_status_word[7], 0);
      @(posedge pclk) trap <= 1'b1;
      @(posedge pclk) trap <= 1'b0;
      wait_vec;
      chk(vector_addr_reg, 20'h0007E);
      chk(push_last, 20'h00016);
      // trap left by its own return
      go_restore(8'h86);
      @(negedge pclk) chk(program_status_word, 8'h86);
      @(posedge pclk) push <= 1'b1;
      @(posedge pclk) push <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(push_last[7:0], 8'h86);
    end
  endtask
  initial begin
    num_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_edges;
    t_accept;
    t_trap;
    tally_and_finish;
  end
endmodule
